// ---- core/adcso_pkg.sv ----
// Shared constants and types for the converter serial and standalone output logic
package adcso_pkg;

  // Result and serial word geometry
  localparam int ADCSO_RESULT_BITS = 12;
  localparam int ADCSO_WORD_BITS   = 16;
  localparam int ADCSO_PAD_BITS    = ADCSO_WORD_BITS - ADCSO_RESULT_BITS;
  localparam int ADCSO_BUF_DEPTH   = 2;

  // Bit counter: counts falling serial clock edges within a frame
  localparam logic [4:0] ADCSO_CNT_RESET = 5'h00;
  localparam logic [4:0] ADCSO_CNT_FULL  = 5'h10;
  localparam int         ADCSO_MSB_POS   = ADCSO_WORD_BITS - 1;

  // Idle pin levels between conversions
  localparam logic ADCSO_IDLE_CLK    = 1'b1;
  localparam logic ADCSO_IDLE_DATA   = 1'b0;
  localparam logic ADCSO_IDLE_STROBE = 1'b0;
  localparam logic ADCSO_IDLE_BUSY_N = 1'b1;

  // Synchroniser lanes for pins from outside the clock domain
  localparam int ADCSO_SYNC_LANES = 5;
  localparam int ADCSO_LANE_LCLK  = 0;
  localparam int ADCSO_LANE_CONV  = 1;
  localparam int ADCSO_LANE_CS    = 2;
  localparam int ADCSO_LANE_CONT  = 3;
  localparam int ADCSO_LANE_ALONE = 4;
  localparam logic [4:0] ADCSO_SYNC_RESET = 5'h07;

  // Conversion sequencer states
  typedef enum {
    ADCSO_IDLE,
    ADCSO_REQ,
    ADCSO_WAIT_EDGE,
    ADCSO_SHIFT,
    ADCSO_FINISH
  } adcso_state_type;

  // Serial output pins travel together
  typedef struct packed {
    logic serial_clk;
    logic serial_data_out;
    logic serial_valid_strobe;
  } adcso_serial_type;

  // Result word handed over by the successive approximation core
  typedef struct packed {
    logic                         valid;
    logic [ADCSO_RESULT_BITS-1:0] data;
  } adcso_result_type;

endpackage

// ---- core/adcso_buffer.sv ----
// Two-entry valid/ready buffer between the conversion core and the serialiser
`timescale 1ns/1ps
module adcso_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Pointer wrap and occupancy; ready is registered so the source sees a clean level
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
    end
    next_count    = count + CW'(push) - CW'(pop);
    next_in_ready = (next_count != CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage carries data only, so it needs no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// ---- core/adcso_serial_port.sv ----
// Serial result port and standalone parallel output of the sampling converter
//
// Overview of operation
// [RL1] Format select low: gated clock, serial clock and data quiet outside conversion.
// [RL2] Gated mode: first falling serial clock edge already sees a valid bit.
// [RL3] Result shifts out on serial data, clocked by serial clock, during conversion.
// [RL4] Receiver takes a 16-bit word and reads it after sixteen bits.
// [RL5] Format select high: serial clock runs continuously; strobe alone marks data.
// [RL6] Continuous mode: strobe marks valid data; receiver may invert it for framing.
// [RL7] Data is valid at serial clock falling edges; rising-edge receivers invert clock.
// [RL8] Receivers needing a free-running clock are used only with continuous mode.
// [RL9] Standalone mode 2: active-low chip select pulse starts a conversion.
// [RL10] Standalone chip select pulse lasts longer than conversion plus busy delay.
// [RL11] Standalone: busy drives read; latch takes parallel result on busy rising.
// [RL12] Serial use runs mode 1: convert-start pulse begins each conversion.
// [RL13] Host never reads the converter while a conversion is in progress.
// [RL14] Gated mode idles serial clock and data at fixed levels between conversions.
`timescale 1ns/1ps
module adcso_serial_port
  import adcso_pkg::*;
#(
  parameter int RESULT_BITS = adcso_pkg::ADCSO_RESULT_BITS
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         link_clk_pin,
  input  wire logic                         convert_start_n,
  input  wire logic                         chip_select_n,
  input  wire logic                         clock_continuous_sel,
  input  wire logic                         standalone_sel,
  input  wire adcso_pkg::adcso_result_type  core_result,
  output logic                              core_ready,
  output logic                              sample_request,
  output logic                              busy_n,
  output logic [RESULT_BITS-1:0]            parallel_result_bits,
  output adcso_pkg::adcso_serial_type       serial_link
);

  // Synchroniser and edge history
  logic [ADCSO_SYNC_LANES-1:0] sync_meta;
  logic [ADCSO_SYNC_LANES-1:0] sync_pin;
  logic                        lclk_prev;
  logic                        conv_prev;
  logic                        cs_prev;
  logic                        lclk_rise;
  logic                        lclk_fall;
  logic                        start_edge;
  logic                        continuous;

  // Sequencer state
  adcso_state_type             state;
  adcso_state_type             next_state;
  logic [ADCSO_WORD_BITS-1:0]  shift_word;
  logic [ADCSO_WORD_BITS-1:0]  next_shift_word;
  logic [ADCSO_WORD_BITS-1:0]  frame_word;
  logic [ADCSO_WORD_BITS-1:0]  next_frame_word;
  logic [4:0]                  fall_cnt;
  logic [4:0]                  next_fall_cnt;
  logic                        next_sample_request;
  logic                        next_busy_n;
  logic [RESULT_BITS-1:0]      next_parallel_result_bits;
  adcso_serial_type            next_serial_link;

  // Buffer drain side
  logic                        buf_valid;
  logic [RESULT_BITS-1:0]      buf_data;
  logic                        buf_take;

  // Two flip-flops on every pin from outside; only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= ADCSO_SYNC_RESET;
      sync_pin  <= ADCSO_SYNC_RESET;
      lclk_prev <= 1'b1;
      conv_prev <= 1'b1;
      cs_prev   <= 1'b1;
    end else begin
      sync_meta <= {standalone_sel, clock_continuous_sel, chip_select_n,
                    convert_start_n, link_clk_pin};
      sync_pin  <= sync_meta;
      lclk_prev <= sync_pin[ADCSO_LANE_LCLK];
      conv_prev <= sync_pin[ADCSO_LANE_CONV];
      cs_prev   <= sync_pin[ADCSO_LANE_CS];
    end
  end

  assign lclk_rise  = sync_pin[ADCSO_LANE_LCLK] & ~lclk_prev;
  assign lclk_fall  = ~sync_pin[ADCSO_LANE_LCLK] & lclk_prev;
  assign continuous = sync_pin[ADCSO_LANE_CONT];

  // Start source follows the mode; only a falling edge counts, so a long select is harmless
  assign start_edge = sync_pin[ADCSO_LANE_ALONE]
                    ? (cs_prev & ~sync_pin[ADCSO_LANE_CS])       // RL9
                    : (conv_prev & ~sync_pin[ADCSO_LANE_CONV]);  // RL12

  // Result buffer keeps a word safe while the serialiser is still busy
  adcso_buffer #(
    .WIDTH (RESULT_BITS),
    .DEPTH (ADCSO_BUF_DEPTH)
  ) i_adcso_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (core_result.valid),
    .in_data   (core_result.data),
    .in_ready  (core_ready),
    .out_ready (buf_take),
    .out_valid (buf_valid),
    .out_data  (buf_data)
  );

  assign buf_take = (state == ADCSO_REQ) && buf_valid;

  // Conversion sequencer and serial shifter
  always_comb begin
    next_state                = state;
    next_shift_word           = shift_word;
    next_frame_word           = frame_word;
    next_fall_cnt             = fall_cnt;
    next_sample_request       = 1'b0;
    next_busy_n               = busy_n;
    next_parallel_result_bits = parallel_result_bits;
    case (state)
      ADCSO_IDLE: begin
        // Starts during a conversion are ignored, the host must wait for busy
        if (start_edge) begin
          next_state          = ADCSO_REQ;
          next_sample_request = 1'b1;
          next_busy_n         = 1'b0;
        end
      end
      ADCSO_REQ: begin
        if (buf_valid) begin
          next_shift_word = {{ADCSO_PAD_BITS{1'b0}}, buf_data};  // RL4
          next_frame_word = {{ADCSO_PAD_BITS{1'b0}}, buf_data};
          next_state      = ADCSO_WAIT_EDGE;
        end
      end
      ADCSO_WAIT_EDGE: begin
        // Open the frame on a rising edge so the first falling edge finds the MSB
        if (lclk_rise) begin
          next_state    = ADCSO_SHIFT;  // RL2
          next_fall_cnt = ADCSO_CNT_RESET;
        end
      end
      ADCSO_SHIFT: begin
        if (lclk_fall) begin
          next_fall_cnt = fall_cnt + 5'h01;
        end
        if (lclk_rise) begin
          if (fall_cnt == ADCSO_CNT_FULL) begin
            next_state                = ADCSO_FINISH;
            next_parallel_result_bits = frame_word[RESULT_BITS-1:0];  // RL11
          end else begin
            next_shift_word = {shift_word[ADCSO_WORD_BITS-2:0], 1'b0};  // RL3
          end
        end
      end
      ADCSO_FINISH: begin
        // Busy rises one cycle after the result settles, so the latch edge is clean
        next_busy_n = ADCSO_IDLE_BUSY_N;  // RL11
        next_state  = ADCSO_IDLE;
      end
      default: begin
        next_state  = ADCSO_IDLE;
        next_busy_n = ADCSO_IDLE_BUSY_N;
      end
    endcase
  end

  // Serial pins; data changes only with a rising serial clock edge
  always_comb begin
    next_serial_link = '{serial_clk:          ADCSO_IDLE_CLK,
                         serial_data_out:     ADCSO_IDLE_DATA,
                         serial_valid_strobe: ADCSO_IDLE_STROBE};
    if (continuous) begin
      next_serial_link.serial_clk = sync_pin[ADCSO_LANE_LCLK];  // RL5
    end
    if (next_state == ADCSO_SHIFT) begin
      next_serial_link.serial_clk          = sync_pin[ADCSO_LANE_LCLK];  // RL7
      next_serial_link.serial_data_out     = next_shift_word[ADCSO_MSB_POS];  // RL3
      next_serial_link.serial_valid_strobe = continuous;  // RL6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                <= ADCSO_IDLE;
      shift_word           <= '0;
      frame_word           <= '0;
      fall_cnt             <= ADCSO_CNT_RESET;
      sample_request       <= 1'b0;
      busy_n               <= ADCSO_IDLE_BUSY_N;
      parallel_result_bits <= '0;
      serial_link          <= '{serial_clk:          ADCSO_IDLE_CLK,
                                serial_data_out:     ADCSO_IDLE_DATA,
                                serial_valid_strobe: ADCSO_IDLE_STROBE};  // RL1
    end else begin
      state                <= next_state;
      shift_word           <= next_shift_word;
      frame_word           <= next_frame_word;
      fall_cnt             <= next_fall_cnt;
      sample_request       <= next_sample_request;
      busy_n               <= next_busy_n;
      parallel_result_bits <= next_parallel_result_bits;
      serial_link          <= next_serial_link;  // RL14
    end
  end

  // Checks next to the logic they guard

  sequence s_frame_open;
    (state == ADCSO_WAIT_EDGE) ##1 (state == ADCSO_SHIFT);
  endsequence

  sequence s_frame_close;
    (state == ADCSO_SHIFT) ##1 (state == ADCSO_FINISH);
  endsequence

  property p_gated_idle_quiet;
    @(posedge clk) disable iff (!rst_n)
      (!continuous && state == ADCSO_IDLE && $past(state) == ADCSO_IDLE)
        |-> (serial_link.serial_clk == ADCSO_IDLE_CLK)
            && (serial_link.serial_data_out == ADCSO_IDLE_DATA);
  endproperty
  a_gated_idle_quiet: assert property (p_gated_idle_quiet)  // RL1
    else $error("serial pins active while idle in gated mode");

  property p_first_bit_ready;
    @(posedge clk) disable iff (!rst_n)
      s_frame_open |-> serial_link.serial_clk
                       && (serial_link.serial_data_out == frame_word[ADCSO_MSB_POS]);
  endproperty
  a_first_bit_ready: assert property (p_first_bit_ready)  // RL2
    else $error("first bit not presented when frame opens");

  property p_busy_during_shift;
    @(posedge clk) disable iff (!rst_n)
      (state == ADCSO_SHIFT) |-> !busy_n && (fall_cnt <= ADCSO_CNT_FULL);
  endproperty
  a_busy_during_shift: assert property (p_busy_during_shift)  // RL3
    else $error("shifting outside a conversion");

  property p_sixteen_falls;
    @(posedge clk) disable iff (!rst_n)
      s_frame_close |-> ($past(fall_cnt) == ADCSO_CNT_FULL);
  endproperty
  a_sixteen_falls: assert property (p_sixteen_falls)  // RL4
    else $error("frame did not carry sixteen clock edges");

  property p_continuous_clock;
    @(posedge clk) disable iff (!rst_n)
      (continuous && $past(continuous) && lclk_rise) |=> serial_link.serial_clk;
  endproperty
  a_continuous_clock: assert property (p_continuous_clock)  // RL5
    else $error("serial clock stopped in continuous mode");

  property p_strobe_frames;
    @(posedge clk) disable iff (!rst_n)
      $rose(serial_link.serial_valid_strobe) |-> (state == ADCSO_SHIFT) && continuous
                                                 && $past(state) == ADCSO_WAIT_EDGE;
  endproperty
  a_strobe_frames: assert property (p_strobe_frames)  // RL6
    else $error("strobe outside a frame");

  property p_data_stable_at_fall;
    @(posedge clk) disable iff (!rst_n)
      $fell(serial_link.serial_clk) |-> $stable(serial_link.serial_data_out);
  endproperty
  a_data_stable_at_fall: assert property (p_data_stable_at_fall)  // RL7
    else $error("serial data moved on a falling clock");

  property p_select_starts;
    @(posedge clk) disable iff (!rst_n)
      (state == ADCSO_IDLE && sync_pin[ADCSO_LANE_ALONE] && cs_prev
       && !sync_pin[ADCSO_LANE_CS]) |=> !busy_n && sample_request;
  endproperty
  a_select_starts: assert property (p_select_starts)  // RL9
    else $error("chip select did not start a standalone conversion");

  property p_busy_latch;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> (parallel_result_bits == frame_word[RESULT_BITS-1:0])
                        && $stable(parallel_result_bits);
  endproperty
  a_busy_latch: assert property (p_busy_latch)  // RL11
    else $error("result not settled at busy rising");

  property p_convert_starts;
    @(posedge clk) disable iff (!rst_n)
      (state == ADCSO_IDLE && !sync_pin[ADCSO_LANE_ALONE] && conv_prev
       && !sync_pin[ADCSO_LANE_CONV]) |=> !busy_n ##1 (state != ADCSO_IDLE);
  endproperty
  a_convert_starts: assert property (p_convert_starts)  // RL12
    else $error("convert start did not begin a conversion");

  property p_gated_no_edges;
    @(posedge clk) disable iff (!rst_n)
      (!continuous && state != ADCSO_SHIFT && $past(state) != ADCSO_SHIFT)
        |-> $stable(serial_link.serial_clk);
  endproperty
  a_gated_no_edges: assert property (p_gated_no_edges)  // RL14
    else $error("spurious serial clock edge between conversions");

endmodule

// ---- verification/adcso_dsp_receiver.sv ----
// Behavioural serial receiver and parallel result latch facing the converter
`timescale 1ns/1ps
module adcso_dsp_receiver (
  input  wire logic                                   clock_continuous_sel,
  input  wire logic                                   busy_n,
  input  wire logic [adcso_pkg::ADCSO_RESULT_BITS-1:0] parallel_result_bits,
  input  wire adcso_pkg::adcso_serial_type            serial_link,
  output logic      [adcso_pkg::ADCSO_WORD_BITS-1:0]   rx_word,
  output int                                          rx_words,
  output logic      [adcso_pkg::ADCSO_RESULT_BITS-1:0] latch_word
);
  import adcso_pkg::*;
  logic [ADCSO_WORD_BITS-1:0] shift_reg;
  int                         bit_count;
  logic                       sclk_inv;
  logic                       frame_sync_n;

  // Inverted copies, as a rising-edge receiver with a low-active frame input needs
  assign sclk_inv     = ~serial_link.serial_clk;
  assign frame_sync_n = ~serial_link.serial_valid_strobe;

  // Receiver starts empty
  initial begin
    shift_reg = '0;
    bit_count = 0;
    rx_word = '0;
    rx_words = 0;
    latch_word = '0;
  end

  // One bit per serial clock fall; strobe low in continuous mode means no frame
  always @(posedge sclk_inv) begin
    if (clock_continuous_sel && frame_sync_n) begin
      bit_count = 0;
    end else begin
      shift_reg = {shift_reg[ADCSO_WORD_BITS-2:0], serial_link.serial_data_out};
      bit_count = bit_count + 1;
      if (bit_count == ADCSO_WORD_BITS) begin
        rx_word = shift_reg;
        rx_words = rx_words + 1;
        bit_count = 0;
      end
    end
  end

  // Latch reads only when busy returns high, never mid-conversion
  always @(posedge busy_n) begin
    latch_word = parallel_result_bits;
  end
endmodule

// ---- verification/adcso_serial_port_tb.sv ----
// Self-checking bench for the converter serial and standalone output port
`timescale 1ns/1ps
module adcso_serial_port_tb;
  import adcso_pkg::*;
  logic             clk;
  logic             rst_n;
  logic             link_clk_pin;
  logic             convert_start_n;
  logic             chip_select_n;
  logic             clock_continuous_sel;
  logic             standalone_sel;
  adcso_result_type core_result;
  logic             core_ready;
  logic             sample_request;
  logic             busy_n;
  logic [11:0]      parallel_result_bits;
  adcso_serial_type serial_link;
  logic [15:0]      rx_word;
  int               rx_words;
  logic [11:0]      latch_word;
  int               n_fail = 0;
  int               n_checks = 0;
  int               n_sclk = 0;
  int               n_sreq = 0;

  adcso_serial_port i_adcso_serial_port (
    .clk(clk), .rst_n(rst_n), .link_clk_pin(link_clk_pin),
    .convert_start_n(convert_start_n), .chip_select_n(chip_select_n),
    .clock_continuous_sel(clock_continuous_sel), .standalone_sel(standalone_sel),
    .core_result(core_result), .core_ready(core_ready),
    .sample_request(sample_request), .busy_n(busy_n),
    .parallel_result_bits(parallel_result_bits), .serial_link(serial_link));

  adcso_dsp_receiver i_adcso_dsp_receiver (
    .clock_continuous_sel(clock_continuous_sel), .busy_n(busy_n),
    .parallel_result_bits(parallel_result_bits), .serial_link(serial_link),
    .rx_word(rx_word), .rx_words(rx_words), .latch_word(latch_word));

  // System clock, and a link clock offset so its edges never meet clk edges
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk_pin = 1'b1;
    #7;
    forever #160 link_clk_pin = ~link_clk_pin;
  end

  // Event counters for serial clock activity and start pulses
  always @(serial_link.serial_clk) n_sclk++;
  always @(posedge clk) begin
    if (sample_request === 1'b1) n_sreq++;
  end

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    for (int i = 0; i < lim && busy_n !== lvl; i++) begin
      @(negedge clk);
    end
    check_val({15'h0000, busy_n}, {15'h0000, lvl});
  endtask

  // Source holds valid until the buffer has room
  task automatic push(input logic [11:0] d);
    @(negedge clk);
    core_result.valid = 1'b1;
    core_result.data = d;
    while (core_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    core_result.valid = 1'b0;
  endtask

  task automatic pulse_conv;
    @(negedge clk);
    convert_start_n = 1'b0;
    repeat (4) @(negedge clk);
    convert_start_n = 1'b1;
  endtask

  // Watches 40 clocks between conversions: clock moving or not, data and strobe low
  task automatic watch_idle(input logic moving);
    int e0;
    e0 = n_sclk;
    repeat (40) @(negedge clk);
    check_val(16'(n_sclk != e0), 16'(moving));
    check_val({14'h0, serial_link.serial_data_out, serial_link.serial_valid_strobe}, 16'h0);
  endtask

  task automatic t_reset_idle;
    check_val({10'h0, serial_link, busy_n, core_ready, sample_request}, 16'h0026);
    check_val({4'h0, parallel_result_bits}, 16'h0000);
    watch_idle(1'b0);
  endtask

  // Two words fill the buffer with nobody draining it
  task automatic t_buffer_full;
    push(12'ha5c);
    push(12'h3f1);
    repeat (3) @(negedge clk);
    check_val({15'h0, core_ready}, 16'h0000);
  endtask

  task automatic t_gated_conv;
    int e0;
    int w0;
    int s0;
    e0 = n_sclk;
    w0 = rx_words;
    s0 = n_sreq;
    pulse_conv();
    wait_busy(1'b0, 20);
    wait_busy(1'b1, 400);
    check_val(rx_word, 16'h0a5c);
    check_val(16'(rx_words - w0), 16'h0001);
    check_val(16'(n_sreq - s0), 16'h0001);
    check_val(16'(n_sclk - e0), 16'h0020);
    check_val({4'h0, parallel_result_bits}, 16'h0a5c);
    check_val({15'h0, core_ready}, 16'h0001);
    watch_idle(1'b0);
  endtask

  // Continuous clock; a second start mid-frame must be ignored
  task automatic t_cont_conv;
    int w0;
    int s0;
    push(12'hc3b);
    @(negedge clk);
    clock_continuous_sel = 1'b1;
    repeat (10) @(negedge clk);
    watch_idle(1'b1);
    w0 = rx_words;
    s0 = n_sreq;
    pulse_conv();
    wait_busy(1'b0, 20);
    repeat (20) @(negedge clk);
    pulse_conv();
    wait_busy(1'b1, 400);
    check_val(rx_word, 16'h03f1);
    check_val(16'(rx_words - w0), 16'h0001);
    check_val(16'(n_sreq - s0), 16'h0001);
  endtask

  // Mode 2: convert pin ignored, long chip select starts, latch takes the result
  task automatic t_standalone;
    @(negedge clk);
    standalone_sel = 1'b1;
    repeat (6) @(negedge clk);
    pulse_conv();
    repeat (20) @(negedge clk);
    check_val({15'h0, busy_n}, 16'h0001);
    @(negedge clk);
    chip_select_n = 1'b0;
    wait_busy(1'b0, 20);
    wait_busy(1'b1, 400);
    repeat (3) @(negedge clk);
    chip_select_n = 1'b1;
    check_val({4'h0, latch_word}, 16'h0c3b);
    check_val({4'h0, parallel_result_bits}, 16'h0c3b);
  endtask

  task automatic print_verdict;
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: reset for 16 clocks, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    convert_start_n = 1'b1;
    chip_select_n = 1'b1;
    clock_continuous_sel = 1'b0;
    standalone_sel = 1'b0;
    core_result = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_idle();
    t_buffer_full();
    t_gated_conv();
    t_cont_conv();
    t_standalone();
    print_verdict();
  end

  // Hang guard, well past the expected run of about 610 clocks
  initial begin
    #(5000 * 40);
    n_fail++;
    print_verdict();
  end
endmodule
